/* src/nrin_node.sv */
/*
 Relay and input node: AHB-Lite register slave, latching relay drive,
 customer input reporting, service and run indicator patterns.
 Assumes buttons and contact inputs are asynchronous active-low pins and
 that node firmware reports its condition through the node register.
*/
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
// What this block does
// RULE1 - Held service button lights service indicator
// RULE2 - Restart button pulses processor restart once
// RULE3 - Installed with application: service indicator dark
// RULE4 - No application or error: indicator steady
// RULE5 - Uninstalled application: indicator blinks one second
// RULE6 - Watchdog fault: brief flash every 2.5s
// RULE7 - Running application: run indicator blinks
// RULE8 - Closed contact reports one, open zero
// RULE9 - Command update drives affected relay
// RULE10 - Word bit n drives relay n+1
// RULE11 - Relay command is word OR bit
// RULE12 - Bit array index zero is ignored
// RULE13 - Word takes 16 bits, elements one bit
// RULE14 - Power-up resets relays before commanded state
// RULE15 - Prescaler timing, indicator pattern by priority
module nrin_node
    import nrin_pkg::*;
#(
    parameter int TICK_CYCLES = NRIN_TICK_CYCLES,
    parameter int HOLD_CYCLES = NRIN_RELAY_HOLD_CYCLES
)
(
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Pins
    input wire logic service_button_n,
    input wire logic restart_button_n,
    input wire logic [3:0] customer_input_n,
    // Node outputs
    output logic [15:0] relay_drive,
    output logic relay_reset_all,
    output logic relay_update,
    output logic [3:0] customer_input_report,
    output logic service_indicator,
    output logic run_indicator,
    output logic processor_restart
);
    nrin_state_t st;
    nrin_state_t next_st;
    logic pressed;
    logic wrap;
    logic [15:0] cmd;

    function automatic logic [31:0] reg_read(input logic [7:0] a, input nrin_state_t s);
        logic [31:0] r;
        r = '0;
        if (a == NRIN_WORD_OFS)
        begin
            r[15:0] = s.word;
        end
        else if (a == NRIN_BITS_OFS)
        begin
            r[16:0] = s.bits;
        end
        else if (a == NRIN_NODE_OFS)
        begin
            r[4:0] = s.node;
        end
        else if (a == NRIN_STAT_OFS)
        begin
            r[15:0] = s.relay_drive;
            r[NRIN_STAT_RPT_LSB +: 4] = s.report;
            r[NRIN_STAT_SVC_BIT] = s.svc_led;
            r[NRIN_STAT_RUN_BIT] = s.run_led;
            r[NRIN_STAT_INIT_BIT] = s.relay_reset_all;
            r[NRIN_STAT_BTN_BIT] = !s.svc_s[1];
        end
        return r;
    endfunction

    always_comb
    begin
        next_st = st;
        pressed = !st.svc_s[1];
        wrap = st.tick_cnt == 32'(TICK_CYCLES - 1);
        cmd = st.word | st.bits[16:1]; // RULE11 RULE12 RULE10
        // Synchronisers: first stage feeds only the second
        next_st.svc_s = {st.svc_s[0], service_button_n};
        next_st.rst_s = {st.rst_s[0], restart_button_n};
        next_st.in_s = {st.in_s[0], customer_input_n};
        next_st.report = ~st.in_s[1]; // RULE8
        // Restart on the falling edge of the debounced-free button level
        next_st.rst_prev = st.rst_s[1];
        next_st.restart = st.rst_prev && !st.rst_s[1]; // RULE2
        // Bus data phase; zero wait, always OKAY
        if (st.d_act && st.d_write)
        begin
            if (st.d_addr == NRIN_WORD_OFS)
            begin
                next_st.word = hwdata[15:0]; // RULE13
            end
            else if (st.d_addr == NRIN_BITS_OFS)
            begin
                next_st.bits = hwdata[16:0]; // RULE13
            end
            else if (st.d_addr == NRIN_NODE_OFS)
            begin
                next_st.node = nrin_node_t'(hwdata[4:0]);
            end
        end
        // A restarted processor is no longer running; this beats a write
        if (next_st.restart)
        begin
            next_st.node.running = 1'b0;
        end
        next_st.d_act = 1'b0;
        if (hsel && hready && htrans[1])
        begin
            next_st.d_act = hsize == 3'h2;
            next_st.d_write = hwrite;
            next_st.d_addr = {haddr[7:2], 2'h0};
            next_st.rdata = hwrite ? 32'h0 : reg_read({haddr[7:2], 2'h0}, next_st);
        end
        // Prescaler for all indicator timing
        next_st.tick_cnt = wrap ? 32'h0 : st.tick_cnt + 32'h1; // RULE15
        if (wrap)
        begin
            next_st.blink_cnt = st.blink_cnt + 4'h1;
            if (st.blink_cnt == 4'(NRIN_BLINK_TICKS - 1))
            begin
                next_st.blink_cnt = 4'h0;
                next_st.blink = !st.blink; // RULE5 RULE7
            end
            next_st.flash_cnt = st.flash_cnt + 5'h1;
            if (st.flash_cnt == 5'(NRIN_FLASH_TICKS - 1))
            begin
                next_st.flash_cnt = 5'h0;
            end
        end
        // Service indicator priority
        if (pressed)
        begin
            next_st.svc_led = 1'b1; // RULE1
        end
        else if (st.node.wd_fault)
        begin
            next_st.svc_led = st.flash_cnt == 5'h0; // RULE6
        end
        else if (!st.node.app_present || st.node.app_error)
        begin
            next_st.svc_led = 1'b1; // RULE4
        end
        else if (!st.node.installed)
        begin
            next_st.svc_led = st.blink; // RULE5
        end
        else
        begin
            next_st.svc_led = 1'b0; // RULE3
        end
        next_st.run_led = st.node.running && st.blink; // RULE7
        // Latching relays: reset all first, then follow commands
        next_st.relay_update = 1'b0;
        case (st.phase)
            NRIN_INIT:
            begin
                next_st.relay_drive = 16'h0; // RULE14
                next_st.relay_reset_all = 1'b1;
                next_st.hold_cnt = st.hold_cnt + 32'h1;
                if (st.hold_cnt == 32'(HOLD_CYCLES - 1))
                begin
                    next_st.phase = NRIN_RUN;
                    next_st.relay_reset_all = 1'b0;
                end
            end
            NRIN_RUN:
            begin
                next_st.relay_drive = cmd; // RULE9
                next_st.relay_update = cmd != st.relay_drive;
            end
            default:
            begin
                next_st.phase = NRIN_INIT;
            end
        endcase
    end

    // Clock enable low freezes every flop, bus answers included
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= NRIN_STATE_RST;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign hreadyout = !st.d_act || st.d_act;
    assign hresp = st.d_act && !st.d_act;
    assign hrdata = st.rdata;
    assign relay_drive = st.relay_drive;
    assign relay_reset_all = st.relay_reset_all;
    assign relay_update = st.relay_update;
    assign customer_input_report = st.report;
    assign service_indicator = st.svc_led;
    assign run_indicator = st.run_led;
    assign processor_restart = st.restart;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    svc_held_on_a: assert property (ce && pressed |=> service_indicator) // RULE1
        else $error("service indicator dark while button held");
    restart_one_a: assert property (processor_restart && ce |=> !processor_restart) // RULE2
        else $error("restart pulse longer than one cycle");
    svc_dark_a: assert property (ce && !pressed && st.node == 5'b00110 // RULE3
        |=> !service_indicator)
        else $error("service indicator lit when installed");
    svc_steady_a: assert property (ce && !pressed && !st.node.wd_fault // RULE4
        && !st.node.app_present |=> service_indicator)
        else $error("service indicator not steady without application");
    svc_blink_a: assert property (ce && !pressed && st.node[4:1] == 4'b0001 // RULE5
        |=> service_indicator == $past(st.blink))
        else $error("service indicator not following blink phase");
    flash_short_a: assert property (ce && !pressed && st.node.wd_fault // RULE6
        && st.flash_cnt != 5'h0 |=> !service_indicator)
        else $error("watchdog flash too long");
    blink_hold_a: assert property ($changed(st.blink) |-> $past(wrap && ce)) // RULE7
        else $error("blink phase changed off prescaler tick");
    input_map_a: assert property (ce ##1 ce ##1 ce // RULE8
        |=> customer_input_report == ~$past(customer_input_n, 3))
        else $error("customer report not inverted contact");
    relay_or_a: assert property (ce && st.phase == NRIN_RUN // RULE11
        |=> relay_drive == $past(st.word | st.bits[16:1]))
        else $error("relay drive not word OR bits");
    relay_init_a: assert property (relay_reset_all |-> relay_drive == 16'h0) // RULE14
        else $error("relay driven during power-up reset");

    blink_cov_c: cover property (st.node[4:1] == 4'b0001 && $rose(service_indicator));
    update_cov_c: cover property (relay_update);
    restart_cov_c: cover property (processor_restart);
    flash_cov_c: cover property (st.node.wd_fault && $rose(service_indicator));
endmodule

/* include/nrin_pkg.sv */
/*
 Constants, register map and state types for the relay and input node.
 Assumes a single 125 MHz clock and an AHB-Lite register bus.
*/
package nrin_pkg;
    // Register byte offsets
    localparam logic [7:0] NRIN_WORD_OFS = 8'h00;
    localparam logic [7:0] NRIN_BITS_OFS = 8'h04;
    localparam logic [7:0] NRIN_NODE_OFS = 8'h08;
    localparam logic [7:0] NRIN_STAT_OFS = 8'h0C;
    // Status register field positions
    localparam int NRIN_STAT_RPT_LSB = 16;
    localparam int NRIN_STAT_SVC_BIT = 20;
    localparam int NRIN_STAT_RUN_BIT = 21;
    localparam int NRIN_STAT_INIT_BIT = 22;
    localparam int NRIN_STAT_BTN_BIT = 23;
    // Timing
    localparam int NRIN_CLK_HZ = 125_000_000;
    localparam int NRIN_TICK_MS = 100;
    localparam int NRIN_TICK_CYCLES = NRIN_CLK_HZ / 1000 * NRIN_TICK_MS;
    localparam int NRIN_BLINK_MS = 1000;
    localparam int NRIN_BLINK_TICKS = NRIN_BLINK_MS / NRIN_TICK_MS;
    localparam int NRIN_FLASH_PERIOD_MS = 2500;
    localparam int NRIN_FLASH_TICKS = NRIN_FLASH_PERIOD_MS / NRIN_TICK_MS;
    localparam int NRIN_RELAY_RESET_MS = 50;
    localparam int NRIN_RELAY_HOLD_CYCLES = NRIN_CLK_HZ / 1000 * NRIN_RELAY_RESET_MS;

    typedef enum logic [1:0] {
        NRIN_INIT = 2'b01,
        NRIN_RUN = 2'b10
    } nrin_phase_t;

    // Node condition, written by the node firmware
    typedef struct packed {
        logic wd_fault;
        logic app_error;
        logic installed;
        logic app_present;
        logic running;
    } nrin_node_t;

    typedef struct packed {
        nrin_phase_t phase;
        logic [31:0] hold_cnt;
        logic [15:0] word;
        logic [16:0] bits;
        nrin_node_t node;
        logic [1:0] svc_s;
        logic [1:0] rst_s;
        logic [1:0][3:0] in_s;
        logic rst_prev;
        logic [31:0] tick_cnt;
        logic [4:0] flash_cnt;
        logic [3:0] blink_cnt;
        logic blink;
        logic d_act;
        logic d_write;
        logic [7:0] d_addr;
        logic [15:0] relay_drive;
        logic relay_reset_all;
        logic relay_update;
        logic [3:0] report;
        logic svc_led;
        logic run_led;
        logic restart;
        logic [31:0] rdata;
    } nrin_state_t;

    localparam nrin_state_t NRIN_STATE_RST = '{
        phase: NRIN_INIT,
        svc_s: 2'h3,
        rst_s: 2'h3,
        rst_prev: 1'b1,
        relay_reset_all: 1'b1,
        default: '0
    };
endpackage

/* test/nrin_relay_bank.sv */
/*
 Latching relay bank on the far side of the relay drive outputs.
 Assumes the node pulses relay_update whenever relay_drive changes.
*/
module nrin_relay_bank
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Relay drive from the node
    input wire logic [15:0] relay_drive,
    input wire logic relay_reset_all,
    input wire logic relay_update,
    // Contact state
    output logic [15:0] contacts
);
    timeunit 1ns;
    timeprecision 1ps;
    // Latching coils keep their state across reset; only drive moves them
    initial contacts = 16'hFFFF;
    always @(posedge hclk)
    begin
        if (relay_reset_all)
            contacts <= 16'h0000;
        else if (relay_update)
            contacts <= relay_drive;
    end
endmodule

/* test/testbench.sv */
/*
 Self-checking bench for the relay and input node.
 Assumes hreadyout is the bus hready and short prescale and hold counts.
*/
module testbench;
    import nrin_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    localparam int HC = 8;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic svc_n, rst_n, relay_reset_all, relay_update, svc_led, run_led, restart;
    logic ce;
    logic [3:0] cin_n, report;
    logic [15:0] relay_drive, contacts;
    int err_total, cmp_count, cyc, word_m, bits_m, n, rly_m;
    assign hready = hreadyout;
    nrin_node #(.TICK_CYCLES(TK), .HOLD_CYCLES(HC)) uut (.hclk(hclk), .hresetn(hresetn),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .service_button_n(svc_n),
        .restart_button_n(rst_n), .customer_input_n(cin_n), .relay_drive(relay_drive),
        .relay_reset_all(relay_reset_all), .relay_update(relay_update),
        .customer_input_report(report), .service_indicator(svc_led),
        .run_indicator(run_led), .processor_restart(restart));
    nrin_relay_bank bank (.hclk(hclk), .hresetn(hresetn), .relay_drive(relay_drive),
        .relay_reset_all(relay_reset_all), .relay_update(relay_update),
        .contacts(contacts));
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic report_and_stop();
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Address phase held until hready, then data phase held until hready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic count_lit(input bit run, input int cycles, output int c);
        c = 0;
        repeat (cycles)
        begin
            @(posedge hclk);
            c += ((run ? run_led : svc_led) === 1'b1) ? 1 : 0;
        end
    endtask
    task automatic node_cond(input logic [4:0] v, input bit run, input int exp);
        bus(1'b1, NRIN_NODE_OFS, {27'h0, v});
        repeat (4 * TK) @(posedge hclk);
        count_lit(run, (v[4] ? 25 : 20) * TK, n);
        chk(run ? "run lit cycles" : "service lit cycles", exp, n);
    endtask
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc > 40000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    initial
    begin
        {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        svc_n = 1'b1;
        rst_n = 1'b1;
        cin_n = 4'hF;
        ce = 1'b1;
        hresetn = 1'b0;
        err_total = 0;
        cmp_count = 0;
        cyc = 0;
        void'($urandom(18));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("reset all phase", 1, relay_reset_all);
        repeat (HC + 3) @(posedge hclk);
        chk("reset all end", 0, relay_reset_all);
        chk("drive after reset", 0, relay_drive);
        chk("contacts after reset", 0, contacts);
        for (int i = 0; i < 12; i++)
        begin
            word_m = (i == 0) ? 32'hFFFF_FFFF : $urandom();
            bits_m = (i == 1) ? 1 : $urandom() & 32'h1_FFFF;
            cin_n <= 4'($urandom());
            bus(1'b1, NRIN_WORD_OFS, word_m);
            if (i % 3 != 2)
                bus(1'b1, NRIN_BITS_OFS, bits_m);
            else
                bits_m = 0;
            if (i % 3 == 2)
                bus(1'b1, NRIN_BITS_OFS, 0);
            repeat (3) @(posedge hclk);
            rly_m = (word_m | (bits_m >> 1)) & 32'hFFFF;
            chk("relay drive", rly_m, relay_drive);
            chk("relay contacts", rly_m, contacts);
            chk("input report", 4'(~cin_n), report);
            bus(1'b0, NRIN_STAT_OFS, 0);
            chk("status drive", rly_m, rd[15:0]);
            chk("status report", 4'(~cin_n), rd[19:16]);
        end
        // A write while the clock enable is low must be lost
        ce <= 1'b0;
        bus(1'b1, NRIN_WORD_OFS, ~rly_m);
        repeat (3) @(posedge hclk);
        chk("drive frozen by ce", rly_m, relay_drive);
        ce <= 1'b1;
        bus(1'b0, 8'h10, 0);
        chk("unmapped read", 0, rd);
        chk("response", 0, hresp);
        node_cond(5'h00, 0, 20 * TK);
        node_cond(5'h0A, 0, 20 * TK);
        node_cond(5'h06, 0, 0);
        node_cond(5'h02, 0, 10 * TK);
        node_cond(5'h16, 0, TK);
        node_cond(5'h07, 1, 10 * TK);
        svc_n <= 1'b0;
        repeat (5) @(posedge hclk);
        count_lit(0, 20 * TK, n);
        chk("service held", 20 * TK, n);
        svc_n <= 1'b1;
        rst_n <= 1'b0;
        count_lit(1, 5, n);
        count_lit(1, 20 * TK, n);
        chk("run after restart", 0, n);
        n = 0;
        rst_n <= 1'b1;
        bus(1'b1, NRIN_NODE_OFS, 32'h07);
        rst_n <= 1'b0;
        repeat (12)
        begin
            @(posedge hclk);
            n += (restart === 1'b1) ? 1 : 0;
        end
        chk("restart pulses", 1, n);
        rst_n <= 1'b1;
        report_and_stop();
    end
endmodule
